// >>> phbp_pkg.sv
// Constants shared by the host bus port and its register store.
// Assumes a single core clock domain; pins are sampled, never clocked on.
package phbp_pkg;

  // ---------------------------------------------------------------
  // Register indices selected by register_select
  // ---------------------------------------------------------------
  localparam logic [3:0] PHBP_PORTA_DATA = 4'h0; // Port A data
  localparam logic [3:0] PHBP_PORTB_DATA = 4'h1; // Port B data
  localparam logic [3:0] PHBP_PORTA_DIR = 4'h2; // Port A direction
  localparam logic [3:0] PHBP_PORTB_DIR = 4'h3; // Port B direction
  localparam logic [3:0] PHBP_TMRA_LO = 4'h4; // Timer A low latch
  localparam logic [3:0] PHBP_TMRA_HI = 4'h5; // Timer A high latch
  localparam logic [3:0] PHBP_TMRB_LO = 4'h6; // Timer B low latch
  localparam logic [3:0] PHBP_TMRB_HI = 4'h7; // Timer B high latch
  localparam logic [3:0] PHBP_TOD_TENTHS = 4'h8; // Time of day tenths
  localparam logic [3:0] PHBP_TOD_SEC = 4'h9; // Time of day seconds
  localparam logic [3:0] PHBP_TOD_MIN = 4'hA; // Time of day minutes
  localparam logic [3:0] PHBP_TOD_HOUR = 4'hB; // Time of day hours
  localparam logic [3:0] PHBP_SERIAL_DATA = 4'hC; // Serial data
  localparam logic [3:0] PHBP_INT_CTRL = 4'hD; // Interrupt control
  localparam logic [3:0] PHBP_CTRL_A = 4'hE; // Timer A control
  localparam logic [3:0] PHBP_CTRL_B = 4'hF; // Timer B control

  // ---------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------
  localparam int PHBP_DATA_W = 8; // Data bus width
  localparam int PHBP_ADDR_W = 4; // Register select width
  localparam int PHBP_NUM_REGS = 16; // Register count
  localparam logic [7:0] PHBP_RST_ZERO = 8'h00; // Ordinary register reset
  localparam logic [7:0] PHBP_RST_LATCH = 8'hFF; // Timer latch reset

  // ---------------------------------------------------------------
  // Bus cycle state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PHBP_IDLE = 2'b00, // No selected cycle
    PHBP_READ = 2'b01, // Selected read, bus driven
    PHBP_WRITE = 2'b10 // Selected write, waiting for fall
  } phbp_state_e;

endpackage

// >>> phbp_reg_if.sv
// Carrier between the bus port and its register store.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ns
`default_nettype none
interface phbp_reg_if;
  import phbp_pkg::*;
  logic wr_en; // One-cycle write strobe
  logic [PHBP_ADDR_W-1:0] wr_addr; // Write target
  logic [PHBP_DATA_W-1:0] wr_data; // Write value
  logic [PHBP_ADDR_W-1:0] rd_addr; // Read target
  logic [PHBP_DATA_W-1:0] rd_data; // Stored value of read target
  logic [PHBP_DATA_W-1:0] porta_data; // Port A data register
  logic [PHBP_DATA_W-1:0] portb_data; // Port B data register
  logic [PHBP_DATA_W-1:0] porta_dir; // Port A direction register
  logic [PHBP_DATA_W-1:0] portb_dir; // Port B direction register
  modport port (output wr_en, wr_addr, wr_data, rd_addr,
                input rd_data, porta_data, portb_data, porta_dir, portb_dir);
  modport store (input wr_en, wr_addr, wr_data, rd_addr,
                 output rd_data, porta_data, portb_data, porta_dir, portb_dir);
endinterface
`default_nettype wire

// >>> phbp_regfile.sv
// Sixteen byte registers written by the bus port.
// Assumes writes arrive as single-cycle strobes on the core clock.
`timescale 1ns/1ns
`default_nettype none
module phbp_regfile
  import phbp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  phbp_reg_if.store rif
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [PHBP_DATA_W-1:0] regs [PHBP_NUM_REGS]; // Register array
  logic [PHBP_DATA_W-1:0] next_regs [PHBP_NUM_REGS]; // Next values

  // Reset value per index: latches all ones, others zero
  function automatic logic [PHBP_DATA_W-1:0] rst_val(input int idx);
    logic [PHBP_ADDR_W-1:0] a;
    a = PHBP_ADDR_W'(idx);
    if (a >= PHBP_TMRA_LO && a <= PHBP_TMRB_HI) begin
      return PHBP_RST_LATCH;
    end
    return PHBP_RST_ZERO;
  endfunction

  // Next values: write strobe updates the decoded entry
  always_comb begin
    for (int i = 0; i < PHBP_NUM_REGS; i++) begin
      next_regs[i] = regs[i];
    end
    if (ce && rif.wr_en) begin
      next_regs[rif.wr_addr] = rif.wr_data;
    end
  end

  // Registers, reset to all ones for the timer latches and zero for the rest
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < PHBP_NUM_REGS; i++) begin
        regs[i] <= rst_val(i);
      end
    end else begin
      regs <= next_regs;
    end
  end

  // ---------------------------------------------------------------
  // Read side
  // ---------------------------------------------------------------
  assign rif.rd_data = regs[rif.rd_addr];
  assign rif.porta_data = regs[PHBP_PORTA_DATA];
  assign rif.portb_data = regs[PHBP_PORTB_DATA];
  assign rif.porta_dir = regs[PHBP_PORTA_DIR];
  assign rif.portb_dir = regs[PHBP_PORTB_DIR];

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_latch_reset_ones: assert property (@(posedge clk) $rose(rst_n) |->
    regs[PHBP_TMRA_LO] == PHBP_RST_LATCH && regs[PHBP_TMRB_HI] == PHBP_RST_LATCH
    && regs[PHBP_CTRL_A] == PHBP_RST_ZERO && regs[PHBP_CTRL_B] == PHBP_RST_ZERO)
    else $error("timer latch or control not at reset value");
  a_write_lands: assert property (@(posedge clk) disable iff (!rst_n)
    ce && rif.wr_en |=> regs[$past(rif.wr_addr)] == $past(rif.wr_data))
    else $error("write did not reach selected register");

endmodule // phbp_regfile
`default_nettype wire

// >>> phbp_host_port.sv
// Host bus port: samples the bus pins, decodes reads and writes,
// drives the data bus and the open-drain interrupt line.
// Assumes the phase-two clock and all bus pins are asynchronous to CORE_CLK
// and that function logic supplies the interrupt condition on CORE_CLK.
`timescale 1ns/1ns
`default_nettype none
module phbp_host_port
  import phbp_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic PHASE2,
  input wire logic CHIP_SEL_N,
  input wire logic READ_WRITE,
  input wire logic [3:0] REGISTER_SELECT,
  input wire logic [7:0] HOST_DATA_BUS_IN,
  output logic [7:0] HOST_DATA_BUS_OUT,
  output logic HOST_DATA_BUS_OE,
  output logic IRQ_N_OUT,
  output logic IRQ_N_OE,
  input wire logic INT_COND,
  input wire logic [7:0] PORTA_IN,
  output logic [7:0] PORTA_OUT,
  output logic [7:0] PORTA_OE,
  input wire logic [7:0] PORTB_IN,
  output logic [7:0] PORTB_OUT,
  output logic [7:0] PORTB_OE
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  localparam int SYNC_W = 1 + 1 + 1 + PHBP_ADDR_W + 3 * PHBP_DATA_W; // Sampled pin count
  logic [SYNC_W-1:0] sync1; // First stage, read only by sync2
  logic [SYNC_W-1:0] sync2; // Second stage, safe to use
  logic phi2_s; // Phase-two level
  logic csn_s; // Device select, active low
  logic rw_s; // Direction
  logic [PHBP_ADDR_W-1:0] rs_s; // Register select
  logic [PHBP_DATA_W-1:0] db_s; // Data bus input
  logic [PHBP_DATA_W-1:0] pa_s; // Port A pins
  logic [PHBP_DATA_W-1:0] pb_s; // Port B pins

  // Two flops on every asynchronous pin
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      sync1 <= '0;
      sync2 <= '0;
    end else if (CE) begin
      sync1 <= {PHASE2, CHIP_SEL_N, READ_WRITE, REGISTER_SELECT,
                HOST_DATA_BUS_IN, PORTA_IN, PORTB_IN};
      sync2 <= sync1;
    end
  end

  assign {phi2_s, csn_s, rw_s, rs_s, db_s, pa_s, pb_s} = sync2;

  // ---------------------------------------------------------------
  // Register store
  // ---------------------------------------------------------------
  phbp_reg_if rif ();

  phbp_regfile u_regs (
    .clk (CORE_CLK),
    .rst_n (RESETN),
    .ce (CE),
    .rif (rif)
  );

  // ---------------------------------------------------------------
  // Bus cycle control
  // ---------------------------------------------------------------
  phbp_state_e state; // Current bus cycle
  phbp_state_e next_state; // Next bus cycle
  logic [PHBP_DATA_W-1:0] dout; // Read data held for the bus
  logic [PHBP_DATA_W-1:0] next_dout;
  logic [PHBP_ADDR_W-1:0] waddr; // Write target held until the fall
  logic [PHBP_ADDR_W-1:0] next_waddr;
  logic [PHBP_DATA_W-1:0] wdata; // Write data held until the fall
  logic [PHBP_DATA_W-1:0] next_wdata;
  logic sel; // Selected phase-two high interval
  logic [PHBP_DATA_W-1:0] rd_value; // Value of the addressed register

  assign sel = phi2_s && !csn_s;

  // Read mux: ports show pin levels, others show stored values
  always_comb begin
    rd_value = rif.rd_data;
    case (rs_s)
      PHBP_PORTA_DATA: rd_value = pa_s;
      PHBP_PORTB_DATA: rd_value = pb_s;
      default: rd_value = rif.rd_data;
    endcase
  end

  assign rif.rd_addr = rs_s;

  // Next cycle state and captured values
  always_comb begin
    next_state = state;
    next_dout = dout;
    next_waddr = waddr;
    next_wdata = wdata;
    case (state)
      PHBP_IDLE: begin
        if (sel && rw_s) begin
          next_state = PHBP_READ;
          next_dout = rd_value;
        end else if (sel && !rw_s) begin
          next_state = PHBP_WRITE;
          next_waddr = rs_s;
          next_wdata = db_s;
        end
      end
      PHBP_READ: begin
        // Follow select changes until the interval ends
        if (sel && rw_s) begin
          next_dout = rd_value;
        end else begin
          next_state = PHBP_IDLE;
        end
      end
      PHBP_WRITE: begin
        if (!phi2_s) begin
          next_state = PHBP_IDLE;
        end else if (csn_s || rw_s) begin
          // Select dropped early: abandon without writing
          next_state = PHBP_IDLE;
        end else begin
          // Keep the latest setup until the fall
          next_waddr = rs_s;
          next_wdata = db_s;
        end
      end
      default: next_state = PHBP_IDLE;
    endcase
  end

  // Cycle state registers
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state <= PHBP_IDLE;
      dout <= PHBP_RST_ZERO;
      waddr <= '0;
      wdata <= PHBP_RST_ZERO;
    end else if (CE) begin
      state <= next_state;
      dout <= next_dout;
      waddr <= next_waddr;
      wdata <= next_wdata;
    end
  end

  // Write strobe on the phase-two fall of a selected write
  assign rif.wr_en = CE && (state == PHBP_WRITE) && !phi2_s;
  assign rif.wr_addr = waddr;
  assign rif.wr_data = wdata;

  // Data bus: driven only during a selected read
  assign HOST_DATA_BUS_OUT = dout;
  assign HOST_DATA_BUS_OE = (state == PHBP_READ);

  // ---------------------------------------------------------------
  // Interrupt line
  // ---------------------------------------------------------------
  logic irq_act; // Registered interrupt condition
  logic next_irq_act;

  // Condition passes unchanged to the interrupt register
  always_comb begin
    next_irq_act = INT_COND;
  end

  // Interrupt register
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      irq_act <= 1'b0;
    end else if (CE) begin
      irq_act <= next_irq_act;
    end
  end

  // Open drain: output only ever low, enable while active
  assign IRQ_N_OUT = 1'b0;
  assign IRQ_N_OE = irq_act;

  // ---------------------------------------------------------------
  // Port pins
  // ---------------------------------------------------------------
  assign PORTA_OUT = rif.porta_data;
  assign PORTB_OUT = rif.portb_data;
  assign PORTA_OE = rif.porta_dir;
  assign PORTB_OE = rif.portb_dir;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);

  a_drive_needs_sel: assert property (HOST_DATA_BUS_OE && $past(CE) |->
    $past(phi2_s) && !$past(csn_s) && $past(rw_s))
    else $error("data bus driven outside a selected read");
  a_drive_on_read: assert property (CE && sel && rw_s |=> HOST_DATA_BUS_OE)
    else $error("selected read did not drive the bus");
  a_release_on_low: assert property (CE && !phi2_s |=> !HOST_DATA_BUS_OE)
    else $error("bus still driven after phase-two low");
  a_read_data_match: assert property (CE && sel && rw_s |=>
    HOST_DATA_BUS_OUT == $past(rd_value))
    else $error("read data does not match selected register");
  a_write_on_fall: assert property (CE && state == PHBP_WRITE && !phi2_s |->
    rif.wr_en && rif.wr_addr == waddr && rif.wr_data == wdata ##1 state == PHBP_IDLE)
    else $error("write not committed at phase-two fall");
  a_write_needs_sel: assert property (rif.wr_en && $past(CE) |->
    $past(state) == PHBP_WRITE && $past(phi2_s))
    else $error("write strobe without a selected write interval");
  a_deselect_ignored: assert property (CE && state == PHBP_IDLE && csn_s |=>
    state == PHBP_IDLE && !rif.wr_en)
    else $error("deselected cycle started a transfer");
  a_irq_follows: assert property (CE && INT_COND |=> IRQ_N_OE && !IRQ_N_OUT)
    else $error("interrupt condition not pulling the line low");
  a_irq_released: assert property (CE && !INT_COND |=> !IRQ_N_OE)
    else $error("interrupt line held without condition");
  a_ports_input_reset: assert property (@(posedge CORE_CLK) $rose(RESETN) |->
    PORTA_OE == 8'h00 && PORTB_OE == 8'h00 && PORTA_OUT == 8'h00)
    else $error("ports not inputs after reset");

endmodule // phbp_host_port
`default_nettype wire

// >>> phbp_host_model.sv
// Processor model that runs phase-two bus cycles against the host port.
// Assumes the bench calls cycle() from one process, off the clock edge.
`timescale 1ns/1ns
`default_nettype none
module phbp_host_model (
  input wire logic clk,
  input wire logic [7:0] dev_out,
  input wire logic dev_oe,
  output logic phase2,
  output logic chip_sel_n,
  output logic read_write,
  output logic [3:0] register_select,
  output logic [7:0] host_bus
);
  // ---------------------------------------------------------------
  // Data bus level
  // ---------------------------------------------------------------
  logic [7:0] data_out; // Own drive, or inverse of last byte once released
  // Device wins while enabled, else what the processor side leaves
  assign host_bus = dev_oe ? dev_out : data_out;

  // Idle bus at time zero
  initial begin
    phase2 = 1'b0;
    chip_sel_n = 1'b1;
    read_write = 1'b1;
    register_select = 4'h0;
    data_out = 8'h00;
  end

  // ---------------------------------------------------------------
  // One bus cycle: six edges high, one edge hold, five edges low
  // ---------------------------------------------------------------
  task automatic cycle(input logic p2, input logic csn, input logic rw, input logic [3:0] rs,
                       input logic [7:0] wd, input logic abort, output logic [7:0] rd, output logic saw);
    int i;
    saw = 1'b0;
    @(posedge clk);
    #1;
    phase2 = p2;
    chip_sel_n = csn;
    read_write = rw;
    register_select = rs;
    // Only a write puts the byte on the bus
    if (!rw) begin
      data_out = wd;
    end
    for (i = 0; i < 6; i++) begin
      @(posedge clk);
      #1;
      saw = saw | dev_oe;
      // Deselect early to abandon the cycle
      if (abort && i == 3) begin
        chip_sel_n = 1'b1;
      end
    end
    rd = host_bus;
    phase2 = 1'b0;
    @(posedge clk);
    #1;
    chip_sel_n = 1'b1;
    register_select = ~rs;
    data_out = ~data_out;
    for (i = 0; i < 5; i++) begin
      @(posedge clk);
      #1;
      saw = saw | dev_oe;
    end
  endtask
endmodule // phbp_host_model
`default_nettype wire

// >>> tb_peripheral_host_bus_port.sv
// Self-checking bench for the host bus port.
// Assumes the processor model and pull-ups on ports and interrupt line.
`timescale 1ns/1ns
`default_nettype none
module tb_peripheral_host_bus_port;
  import phbp_pkg::*;
  typedef struct packed {logic [3:0] rs; logic [7:0] wd; logic [7:0] rd;} phbp_row_s;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic core_clk = 1'b0; // Core clock
  logic resetn = 1'b0; // Reset, active low
  logic ce = 1'b1; // Clock enable
  logic int_cond = 1'b0; // Interrupt condition
  logic phase2, chip_sel_n, read_write, host_oe, irq_out, irq_oe, saw;
  logic [3:0] register_select;
  logic [7:0] host_bus, host_out, rd_v, porta_out, porta_oe, portb_out, portb_oe;
  int bad_count = 0; // Mismatches
  int n_tests = 0; // Comparisons
  int i;
  // Pull-ups on undriven pins
  wire logic irq_line = irq_oe ? irq_out : 1'b1;
  wire logic [7:0] pa_pin = (porta_oe & porta_out) | ~porta_oe;
  wire logic [7:0] pb_pin = (portb_oe & portb_out) | ~portb_oe;
  // Write, then read back; port B reads half pull-up
  phbp_row_s rows [16] = '{{4'h2, 8'hFF, 8'hFF}, {4'h0, 8'h3C, 8'h3C}, {4'h3, 8'h0F, 8'h0F},
    {4'h1, 8'hA5, 8'hF5}, {4'h4, 8'h12, 8'h12}, {4'h5, 8'h34, 8'h34}, {4'h6, 8'h56, 8'h56},
    {4'h7, 8'h78, 8'h78}, {4'h8, 8'h9A, 8'h9A}, {4'h9, 8'hBC, 8'hBC}, {4'hA, 8'hDE, 8'hDE},
    {4'hB, 8'hF0, 8'hF0}, {4'hC, 8'h01, 8'h01}, {4'hD, 8'h80, 8'h80}, {4'hE, 8'h7F, 8'h7F},
    {4'hF, 8'hC3, 8'hC3}};

  // Core clock, 100 MHz
  always #5 core_clk = ~core_clk;

  phbp_host_port uut (.CORE_CLK(core_clk), .RESETN(resetn), .CE(ce), .PHASE2(phase2),
    .CHIP_SEL_N(chip_sel_n), .READ_WRITE(read_write), .REGISTER_SELECT(register_select),
    .HOST_DATA_BUS_IN(host_bus), .HOST_DATA_BUS_OUT(host_out), .HOST_DATA_BUS_OE(host_oe),
    .IRQ_N_OUT(irq_out), .IRQ_N_OE(irq_oe), .INT_COND(int_cond), .PORTA_IN(pa_pin),
    .PORTA_OUT(porta_out), .PORTA_OE(porta_oe), .PORTB_IN(pb_pin), .PORTB_OUT(portb_out),
    .PORTB_OE(portb_oe));

  phbp_host_model partner (.clk(core_clk), .dev_out(host_out), .dev_oe(host_oe), .phase2(phase2),
    .chip_sel_n(chip_sel_n), .read_write(read_write), .register_select(register_select),
    .host_bus(host_bus));

  // ---------------------------------------------------------------
  // Compare, bus helpers and closing report
  // ---------------------------------------------------------------
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] rs, input logic [7:0] d);
    partner.cycle(1'b1, 1'b0, 1'b0, rs, d, 1'b0, rd_v, saw);
    check8({7'h00, saw}, 8'h00);
  endtask
  task automatic rd(input logic [3:0] rs, input logic [7:0] exp);
    partner.cycle(1'b1, 1'b0, 1'b1, rs, 8'h00, 1'b0, rd_v, saw);
    check8({7'h00, saw}, 8'h01);
    check8(rd_v, exp);
  endtask
  // Bounded wait for the interrupt line level
  task automatic wait_irq(input logic lvl);
    int k;
    for (k = 0; k < 4 && irq_line !== lvl; k++) begin
      @(posedge core_clk);
      #1;
    end
    check8({7'h00, irq_line}, {7'h00, lvl});
    if (irq_line !== lvl) begin
      summarize();
    end
  endtask
  task automatic summarize;
    $display("compares %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  function automatic logic [7:0] rst_val(input int r);
    return (r < 2 || (r >= 4 && r <= 7)) ? 8'hFF : 8'h00;
  endfunction

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge core_clk);
    #1 resetn = 1'b1;
    for (i = 0; i < 16; i++) begin
      wr(rows[i].rs, rows[i].wd);
      rd(rows[i].rs, rows[i].rd);
    end
    check8(porta_oe, 8'hFF);
    check8(portb_out, 8'hA5);
    // Deselected write and read leave all alone
    partner.cycle(1'b1, 1'b1, 1'b0, 4'h4, 8'h55, 1'b0, rd_v, saw);
    check8({7'h00, saw}, 8'h00);
    partner.cycle(1'b1, 1'b1, 1'b1, 4'h4, 8'h00, 1'b0, rd_v, saw);
    check8({7'h00, saw}, 8'h00);
    rd(4'h4, 8'h12);
    // Selected write with phase-two held low
    partner.cycle(1'b0, 1'b0, 1'b0, 4'h5, 8'h66, 1'b0, rd_v, saw);
    rd(4'h5, 8'h34);
    // Write abandoned by deselect in mid-phase
    partner.cycle(1'b1, 1'b0, 1'b0, 4'h6, 8'h77, 1'b1, rd_v, saw);
    rd(4'h6, 8'h56);
    // Clock enable low freezes the interrupt register
    ce = 1'b0;
    int_cond = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    check8({7'h00, irq_line}, 8'h01);
    ce = 1'b1;
    wait_irq(1'b0);
    // Interrupt pulls the line low, then lets go
    int_cond = 1'b1;
    wait_irq(1'b0);
    check8({7'h00, irq_out}, 8'h00);
    int_cond = 1'b0;
    wait_irq(1'b1);
    // Second reset in mid-run
    resetn = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    check8(porta_oe | portb_oe, 8'h00);
    check8(porta_out | portb_out, 8'h00);
    resetn = 1'b1;
    for (i = 0; i < 16; i++) begin
      rd(4'(i), rst_val(i));
    end
    summarize();
  end
endmodule // tb_peripheral_host_bus_port
`default_nettype wire
